// ==== design/lcc_consts.svh ====
// Offsets, field positions, reset values and codes of the channel config bank.
// Assumes byte offsets sit in the low bits of the APB address.
`ifndef LCC_CONSTS_SVH
`define LCC_CONSTS_SVH

// ----------------------------------------
// Register indices and address width
// ----------------------------------------
`define LCC_IDX_SCALE 12'h007
`define LCC_IDX_RAMCTL 12'h008
`define LCC_IDX_RAMDAT 12'h009
`define LCC_IDX_RXCFG 12'h00a
`define LCC_IDX_WSEL 12'h00b
`define LCC_IDX_STAT 12'h00c
`define LCC_ADDR_W 14

// ----------------------------------------
// Reset values and field masks
// ----------------------------------------
`define LCC_RST_SCALE 8'h36
`define LCC_RST_RAMCTL 8'h00
`define LCC_RST_RAMDAT 8'h00
`define LCC_RST_RXCFG 8'h47
`define LCC_RST_WSEL 8'h02
`define LCC_MASK_SCALE 8'h3f
`define LCC_MASK_RAMCTL 8'h7f
`define LCC_MASK_RAMDAT 8'h7f
`define LCC_MASK_WSEL 8'h0f

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LCC_BIT_RAM_EN 6
`define LCC_BIT_RAM_RD 5
`define LCC_BIT_CLK_HIGH 7
`define LCC_BIT_FLOAT 6
`define LCC_BIT_PDOWN 5
`define LCC_BIT_FULLIN 4
`define LCC_BIT_SINGLE 3
`define LCC_BIT_WSEL_USER 3

// ----------------------------------------
// Codes
// ----------------------------------------
`define LCC_SCALE_NOMINAL 6'h21
`define LCC_RAM_DEPTH 20
`define LCC_RAM_LAST 5'h13
`define LCC_TERM_120 3'h2
`define LCC_TERM_75 3'h3

`endif

// ==== design/lcc_pkg.sv ====
// Types shared by the channel configuration bank.
// Constants live in lcc_consts.svh.
`default_nettype none

package lcc_pkg;

	typedef enum logic [1:0]
	{
		LCC_MATCH_EXTERNAL = 2'b00,
		LCC_MATCH_120 = 2'b01,
		LCC_MATCH_75 = 2'b10
	} lcc_match_t;

	typedef struct packed
	{
		logic clockHold;
		logic floatOnPowerDown;
		logic powerDown;
		logic fullInternalMatch;
		logic singleEnded;
		logic [2:0] termination;
	} lcc_rxcfg_t;

	typedef struct packed
	{
		logic clockOut;
		logic clockOe;
		logic posOut;
		logic posOe;
		logic negOut;
		logic negOe;
	} lcc_rxpins_t;

	typedef struct packed
	{
		logic matchEnable;
		lcc_match_t matchMode;
		logic fullInternal;
	} lcc_match_cfg_t;

endpackage

`default_nettype wire

// ==== design/lcc_template_ram.sv ====
// Twenty-entry template RAM for the arbitrary transmit waveform.
// Assumes one write or read request per cycle from the register bank.
`timescale 1ns/10ps
`default_nettype none
`include "lcc_consts.svh"

module lcc_template_ram
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Access port
	input wire logic writeStrobe,
	input wire logic [4:0] index,
	input wire logic [6:0] writeValue,
	output logic [6:0] readValue,
	// Waveform engine read port
	input wire logic [4:0] playIndex,
	output logic [6:0] playValue
);
	import lcc_pkg::*;

	logic [6:0] mem [0:`LCC_RAM_DEPTH-1];

	always_ff @(posedge clock)
	begin
		if (writeStrobe)
		begin
			mem[index] <= writeValue;
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			readValue <= 7'h00;
			playValue <= 7'h00;
		end
		else
		begin
			readValue <= mem[index];
			playValue <= mem[playIndex];
		end
	end

endmodule
`default_nettype wire

// ==== design/lcc_channel_regs.sv ====
// Per-channel configuration bank: amplitude scale, template RAM access, receive controls.
// Assumes an APB master on the same clock and receive status from the line logic.
`timescale 1ns/10ps
`default_nettype none
`include "lcc_consts.svh"

module lcc_channel_regs
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`LCC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Receive path status (asynchronous to this clock)
	input wire logic lineSignalLoss,
	input wire logic alarmIndicationSignal,
	input wire logic patternGenEnable,
	input wire logic perChannelMatchEnable,
	// Clocks and data toward the receive pins
	input wire logic referenceLineClock,
	input wire logic recoveredClock,
	input wire logic rxPositiveData,
	input wire logic rxNegativeData,
	// Receive pins
	output lcc_pkg::lcc_rxpins_t rxPins,
	// Transmit path controls
	output logic [5:0] amplitudeScaleCode,
	output logic signed [7:0] amplitudeOffsetPercent,
	output logic [3:0] waveformTemplateSelect,
	output logic [4:0] templatePlayIndexEcho,
	input wire logic [4:0] templatePlayIndex,
	output logic [6:0] templatePlayValue,
	// Receive analogue controls
	output logic rxPowerDown,
	output lcc_pkg::lcc_match_cfg_t rxMatch
);
	import lcc_pkg::*;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Status, clock and data pins come from the line-rate domain; each passes two flops.
	logic [7:0] statusMeta;
	logic [7:0] statusSync;

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			statusMeta <= 8'h00;
			statusSync <= 8'h00;
		end
		else
		begin
			statusMeta <= {lineSignalLoss, alarmIndicationSignal, patternGenEnable,
				perChannelMatchEnable, referenceLineClock, recoveredClock, rxPositiveData,
				rxNegativeData};
			statusSync <= statusMeta;
		end
	end

	logic lossSync;
	logic alarmSync;
	logic patternSync;
	logic matchEnSync;
	assign lossSync = statusSync[7];
	assign alarmSync = statusSync[6];
	assign patternSync = statusSync[5];
	assign matchEnSync = statusSync[4];

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic [5:0] scaleCode;
	logic ramEnable;
	logic ramReadDir;
	logic [4:0] sampleIndex;
	logic [6:0] sampleValue;
	lcc_rxcfg_t rxCfg;
	logic [3:0] waveSelect;

	function automatic logic [11:0] regIndex(input logic [`LCC_ADDR_W-1:0] addr);
		regIndex = addr[`LCC_ADDR_W-1:2];
	endfunction

	function automatic logic [4:0] clampIndex(input logic [4:0] code);
		clampIndex = (code > `LCC_RAM_LAST) ? `LCC_RAM_LAST : code;
	endfunction

	logic accessCycle;
	logic writeCycle;
	logic [11:0] accessIdx;
	logic mapped;
	assign accessCycle = psel & penable & pready;
	assign writeCycle = accessCycle & pwrite;
	assign accessIdx = regIndex(paddr);
	assign mapped = (accessIdx >= `LCC_IDX_SCALE) && (accessIdx <= `LCC_IDX_STAT);

	logic userWave;
	assign userWave = waveSelect[`LCC_BIT_WSEL_USER];

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			scaleCode <= 6'(`LCC_RST_SCALE & `LCC_MASK_SCALE);
		end
		else if (writeCycle && accessIdx == `LCC_IDX_SCALE)
		begin
			scaleCode <= pwdata[5:0];
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			ramEnable <= 1'b0;
			ramReadDir <= 1'b0;
			sampleIndex <= 5'h00;
		end
		else if (writeCycle && accessIdx == `LCC_IDX_RAMCTL)
		begin
			ramEnable <= pwdata[`LCC_BIT_RAM_EN];
			ramReadDir <= pwdata[`LCC_BIT_RAM_RD];
			sampleIndex <= pwdata[4:0];
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			waveSelect <= 4'(`LCC_RST_WSEL);
		end
		else if (writeCycle && accessIdx == `LCC_IDX_WSEL)
		begin
			waveSelect <= pwdata[3:0];
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			rxCfg <= `LCC_RST_RXCFG;
		end
		else if (writeCycle && accessIdx == `LCC_IDX_RXCFG)
		begin
			rxCfg <= pwdata[7:0];
		end
	end

	// ----------------------------------------
	// Template RAM access
	// ----------------------------------------
	// With the user waveform selected: a data write stores to the RAM when access is on in
	// write direction; a read-direction access copies the RAM entry back into the data register.
	logic ramOpen;
	logic dataWrite;
	logic ramWrite;
	logic readPending;
	logic readLoad;
	logic [6:0] ramReadValue;
	assign ramOpen = userWave & ramEnable;
	assign dataWrite = writeCycle && accessIdx == `LCC_IDX_RAMDAT;
	assign ramWrite = dataWrite & ramOpen & ~ramReadDir;

	// The RAM output lags its index by one cycle, so the load waits one more.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			readPending <= 1'b0;
			readLoad <= 1'b0;
		end
		else
		begin
			readPending <= writeCycle && accessIdx == `LCC_IDX_RAMCTL
				&& pwdata[`LCC_BIT_RAM_EN] && pwdata[`LCC_BIT_RAM_RD] && userWave;
			readLoad <= readPending;
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			sampleValue <= 7'(`LCC_RST_RAMDAT & `LCC_MASK_RAMDAT);
		end
		else if (dataWrite)
		begin
			sampleValue <= pwdata[6:0];
		end
		else if (readLoad)
		begin
			sampleValue <= ramReadValue;
		end
	end

	lcc_template_ram templateRam
	(
		.clock(clock),
		.reset(reset),
		.writeStrobe(ramWrite),
		.index(clampIndex(sampleIndex)),
		.writeValue(pwdata[6:0]),
		.readValue(ramReadValue),
		.playIndex(clampIndex(templatePlayIndex)),
		.playValue(templatePlayValue)
	);

	// ----------------------------------------
	// APB read and response
	// ----------------------------------------
	// No wait state: pready rises in the first access cycle, data registered.
	logic [7:0] readByte;

	always_comb
	begin
		case (accessIdx)
			`LCC_IDX_SCALE: readByte = {2'b00, scaleCode};
			`LCC_IDX_RAMCTL: readByte = {1'b0, ramEnable, ramReadDir, sampleIndex};
			`LCC_IDX_RAMDAT: readByte = {1'b0, sampleValue};
			`LCC_IDX_RXCFG: readByte = rxCfg;
			`LCC_IDX_WSEL: readByte = {4'h0, waveSelect};
			`LCC_IDX_STAT: readByte = {4'h0, lossSync, alarmSync, patternSync, matchEnSync};
			default: readByte = 8'h00;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel & ~penable;
			prdata <= {24'h00_0000, readByte};
			pslverr <= psel & ~penable & ~mapped;
		end
	end

	// ----------------------------------------
	// Transmit controls
	// ----------------------------------------
	// Offset from nominal, in code steps of about 3 percent each.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			amplitudeScaleCode <= 6'(`LCC_RST_SCALE & `LCC_MASK_SCALE);
			amplitudeOffsetPercent <= 8'h00;
			waveformTemplateSelect <= 4'(`LCC_RST_WSEL);
			templatePlayIndexEcho <= 5'h00;
		end
		else
		begin
			amplitudeScaleCode <= scaleCode;
			amplitudeOffsetPercent <= 8'(3 * (signed'({2'b00, scaleCode})
				- signed'({2'b00, `LCC_SCALE_NOMINAL})));
			waveformTemplateSelect <= waveSelect;
			templatePlayIndexEcho <= clampIndex(templatePlayIndex);
		end
	end

	// ----------------------------------------
	// Receive controls and pins
	// ----------------------------------------
	lcc_match_t nextMatchMode;

	// Codes 1XX and the unlisted 000/001 both fall back to external matching.
	always_comb
	begin
		case (rxCfg.termination)
			`LCC_TERM_120: nextMatchMode = LCC_MATCH_120;
			`LCC_TERM_75: nextMatchMode = LCC_MATCH_75;
			default: nextMatchMode = LCC_MATCH_EXTERNAL;
		endcase
		if (rxCfg.singleEnded)
		begin
			nextMatchMode = LCC_MATCH_EXTERNAL;
		end
	end

	logic differential;
	assign differential = ~rxCfg.singleEnded;

	// Clock and data pins pass the synchroniser and a register: three cycles of lag.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			rxPowerDown <= 1'b0;
			rxMatch <= '0;
			rxPins <= '0;
		end
		else
		begin
			rxPowerDown <= rxCfg.powerDown;
			rxMatch.matchEnable <= matchEnSync & differential;
			rxMatch.matchMode <= matchEnSync ? nextMatchMode : LCC_MATCH_EXTERNAL;
			rxMatch.fullInternal <= matchEnSync & differential
				& rxCfg.fullInternalMatch;
			if (rxCfg.powerDown)
			begin
				// Enables are low when driven.
				rxPins.clockOut <= 1'b0;
				rxPins.posOut <= 1'b0;
				rxPins.negOut <= 1'b0;
				rxPins.clockOe <= rxCfg.floatOnPowerDown;
				rxPins.posOe <= rxCfg.floatOnPowerDown;
				rxPins.negOe <= rxCfg.floatOnPowerDown;
			end
			else
			begin
				rxPins.clockOe <= 1'b0;
				rxPins.posOe <= 1'b0;
				rxPins.negOe <= 1'b0;
				rxPins.posOut <= statusSync[1];
				rxPins.negOut <= statusSync[0];
				if (lossSync && !alarmSync && !patternSync)
				begin
					rxPins.clockOut <= rxCfg.clockHold ? 1'b1 : statusSync[3];
				end
				else
				begin
					rxPins.clockOut <= statusSync[2];
				end
			end
		end
	end

endmodule
`default_nettype wire

// ==== verif/lcc_regs_sva.sv ====
// Checker for the channel configuration bank.
// Bound to lcc_channel_regs; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
`include "lcc_consts.svh"

module lcc_regs_sva
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`LCC_ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Template play port
	input wire logic [4:0] templatePlayIndex,
	input wire logic [4:0] templatePlayIndexEcho
);
	logic [11:0] idx;
	assign idx = paddr[13:2];
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence read_s;
		psel && penable && pready && !pwrite;
	endsequence

	setup_ready_a: assert property (setup_s |=> pready)
		else $error("no ready after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	unmapped_err_a: assert property (pready && (idx < 12'd7 || idx > 12'd12) |-> pslverr)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (pready && idx >= 12'd7 && idx <= 12'd12 |-> !pslverr)
		else $error("mapped access refused");
	upper_zero_a: assert property (read_s |-> prdata[31:8] == 24'h0000_00)
		else $error("upper read bits set");
	scale_rsvd_a: assert property (read_s and idx == `LCC_IDX_SCALE |-> prdata[7:6] == 2'b00)
		else $error("scale reserved bits set");
	data_rsvd_a: assert property (read_s and idx == `LCC_IDX_RAMDAT |-> !prdata[7])
		else $error("sample reserved bit set");
	// Clamp keeps the engine off the missing entries past the last one
	echo_clamp_a: assert property (!$past(reset) |-> templatePlayIndexEcho ==
		(($past(templatePlayIndex) > 5'd19) ? 5'd19 : $past(templatePlayIndex)))
		else $error("play index not clamped");
endmodule

`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the channel configuration bank.
// Drives APB and the receive status inputs directly.
`timescale 1ns/10ps
`default_nettype none
`include "lcc_consts.svh"

module testbench;
	import lcc_pkg::*;
	logic clock, reset, psel, penable, pwrite, pready, pslverr, err;
	logic [13:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic loss, alarm, pattern, matchEn, refClk, recClk, posD, negD, pdn;
	lcc_rxpins_t pins;
	lcc_match_cfg_t mt;
	logic [5:0] sc;
	logic signed [7:0] ofs;
	logic [3:0] wsel;
	logic [4:0] pidx, echo, a;
	logic [6:0] pval;
	logic [6:0] ram [20];
	logic [7:0] v, cfg;
	int miscompares, checksDone, i;

	lcc_channel_regs lcc_channel_regs_inst (.clock(clock), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .lineSignalLoss(loss),
		.alarmIndicationSignal(alarm), .patternGenEnable(pattern),
		.perChannelMatchEnable(matchEn), .referenceLineClock(refClk),
		.recoveredClock(recClk), .rxPositiveData(posD), .rxNegativeData(negD),
		.rxPins(pins), .amplitudeScaleCode(sc), .amplitudeOffsetPercent(ofs),
		.waveformTemplateSelect(wsel), .templatePlayIndexEcho(echo),
		.templatePlayIndex(pidx), .templatePlayValue(pval), .rxPowerDown(pdn),
		.rxMatch(mt));

	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Starts one edge late so a release and the next setup never share a step
	task automatic apb(input logic wr, input logic [11:0] ix, input logic [31:0] wd);
		int k;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {ix, 2'b00};
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		for (k = 0; k < 20 && pready !== 1'b1; k++)
			@(posedge clock);
		if (k == 20)
		begin
			miscompares++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic ramWr(input logic [4:0] ix, input logic [6:0] d);
		apb(1'b1, `LCC_IDX_RAMCTL, {25'h0, 2'b10, ix});
		apb(1'b1, `LCC_IDX_RAMDAT, {24'($urandom), 1'b0, d});
	endtask

	task automatic play(input logic [4:0] ix, input logic [6:0] d);
		@(posedge clock);
		pidx <= ix;
		repeat (3) @(posedge clock);
		chk(pval, d);
		chk(echo, ix > 5'd19 ? 5'd19 : ix);
	endtask

	function automatic logic [31:0] ofsExp(input logic [5:0] c);
		return 32'(3 * (int'(c) - 33));
	endfunction

	function automatic lcc_rxpins_t pinsExp(input logic [7:0] c);
		if (c[5])
			return c[6] ? 6'b010101 : 6'b000000;
		return {loss && !alarm && !pattern ? (c[7] | refClk) : recClk,
			1'b0, posD, 1'b0, negD, 1'b0};
	endfunction

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, pidx} = '0;
		{loss, alarm, pattern, matchEn, refClk, recClk, posD, negD} = '0;
		reset = 1'b1;
		void'($urandom(99741));
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		apb(1'b0, `LCC_IDX_SCALE, 0);
		chk(rd, 32'h0000_0036);
		apb(1'b0, `LCC_IDX_RAMCTL, 0);
		chk(rd, 32'h0000_0000);
		apb(1'b0, `LCC_IDX_RAMDAT, 0);
		chk(rd, 32'h0000_0000);
		apb(1'b0, `LCC_IDX_RXCFG, 0);
		chk(rd, 32'h0000_0047);
		$display("reset values done");
		for (i = 0; i < 10; i++)
		begin
			v = i == 0 ? 8'h21 : i == 1 ? 8'hc0 : i == 2 ? 8'h3f : 8'($urandom);
			apb(1'b1, `LCC_IDX_SCALE, {24'($urandom), v});
			apb(1'b0, `LCC_IDX_SCALE, 0);
			chk(rd, {24'h0000_00, v & 8'h3f});
			chk(sc, v[5:0]);
			chk(32'(ofs), ofsExp(v[5:0]));
		end
		for (i = 0; i < 2; i++)
		begin
			apb(1'b1, 12'(i * 13), 32'hffff_ffff);
			apb(1'b0, 12'(i * 13), 0);
			chk({rd[30:0], err}, 32'h0000_0001);
		end
		$display("scale and unmapped done");
		apb(1'b1, `LCC_IDX_WSEL, 32'h0000_0008);
		apb(1'b0, `LCC_IDX_WSEL, 0);
		chk(rd, 32'h0000_0008);
		chk(wsel, 4'h8);
		for (i = 0; i < 32; i++)
		begin
			v = 8'($urandom);
			ramWr(5'(i), v[6:0]);
			ram[i > 19 ? 19 : i] = v[6:0];
		end
		for (i = 0; i < 32; i++)
			play(5'(i), ram[i > 19 ? 19 : i]);
		for (i = 0; i < 4; i++)
		begin
			a = i == 3 ? 5'(18 + $urandom % 14) : 5'(i * 9);
			apb(1'b1, `LCC_IDX_RAMCTL, {25'h0, 2'b11, a});
			repeat (2) @(posedge clock);
			apb(1'b0, `LCC_IDX_RAMDAT, 0);
			chk(rd, {25'h0, ram[a > 19 ? 19 : a]});
		end
		// Access disabled, then user waveform not selected: entries must hold
		apb(1'b1, `LCC_IDX_RAMCTL, 32'h0000_0003);
		apb(1'b1, `LCC_IDX_RAMDAT, {24'h00_0000, 1'b1, ~ram[3]});
		apb(1'b0, `LCC_IDX_RAMDAT, 0);
		chk(rd, {25'h0, ~ram[3]});
		play(5'd3, ram[3]);
		apb(1'b1, `LCC_IDX_WSEL, 32'h0000_0007);
		ramWr(5'd4, ~ram[4]);
		play(5'd4, ram[4]);
		$display("template ram done");
		for (i = 0; i < 16; i++)
		begin
			v = 8'($urandom);
			cfg = {v[7:3], 3'(i)};
			@(posedge clock);
			{loss, matchEn, refClk, recClk, posD, negD} <= 6'($urandom);
			{alarm, pattern} <= i[0] ? 2'($urandom) : 2'b00;
			apb(1'b1, `LCC_IDX_RXCFG, {24'($urandom), cfg});
			apb(1'b0, `LCC_IDX_RXCFG, 0);
			chk(rd, {24'h0000_00, cfg});
			chk(pdn, cfg[5]);
			v = cfg[5] && cfg[6] ? 8'h15 : 8'h3f;
			chk(pins & v[5:0], pinsExp(cfg) & v[5:0]);
			chk(mt.matchMode, !matchEn || cfg[3] || cfg[2:0] > 3 || cfg[2:0] < 2 ? 2'b00
				: cfg[0] ? 2'b10 : 2'b01);
			chk(mt.fullInternal, matchEn && !cfg[3] && cfg[4]);
			chk(mt.matchEnable, matchEn && !cfg[3]);
			apb(1'b0, `LCC_IDX_STAT, 0);
			chk(rd, {28'h000_0000, loss, alarm, pattern, matchEn});
		end
		$display("receive config done");
		final_report();
	end
endmodule

bind lcc_channel_regs lcc_regs_sva lcc_regs_sva_inst (.clock(clock), .reset(reset),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .templatePlayIndex(templatePlayIndex),
	.templatePlayIndexEcho(templatePlayIndexEcho));

`default_nettype wire
